/* File: design/pcoc_top.sv */
// Purpose: Peripheral clock output, shared pin select and serial mode
//          control register behind an APB slave.
// Assumes: sleep_req and timer0_out are pclk-domain logic; sub_clock and
//          cfg_serial_option are outside levels and are synchronised.
// Notes:   Full-rate source cannot toggle a flop at pclk, so it is shown
//          by periph_clock_tick held high with the level output high.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "pcoc_defines.svh"
module pcoc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`PCOC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_req,
   input wire logic timer0_out,
   input wire logic sub_clock,
   input wire logic cfg_serial_option,
   input wire pcoc_pkg::pcoc_pin_s port_drive,
   output logic periph_clock_out,
   output logic periph_clock_tick,
   output pcoc_pkg::pcoc_pin_s shared_port_pin,
   output pcoc_pkg::pcoc_pin_s serial_sclk,
   output pcoc_pkg::pcoc_serial_s serial_mode,
   output logic serial_lines_oe_allow,
   output logic spi_ctrl_reinit
);

   // Pick one prescaler bit; shared by output clock and SPI clock paths
   function automatic logic div_tap(
      input logic [`PCOC_PRESC_W-1:0] c,
      input int unsigned b
   );
      return c[b];
   endfunction

   // Full decode of a register address inside the block
   function automatic logic addr_is(
      input logic [`PCOC_ADDR_W-1:0] a,
      input logic [`PCOC_ADDR_W-1:0] ofs
   );
      return a == ofs;
   endfunction

   logic [`PCOC_PRESC_W-1:0] presc;
   logic t0_half;
   logic [1:0] sync_lv;
   logic sub_sync;
   logic cfg_sync;

   pcoc_divider u_div (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .timer0_out(timer0_out),
      .presc(presc),
      .timer0_half(t0_half)
   );

   pcoc_sync2 #(.W(2)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .async_in({sub_clock, cfg_serial_option}),
      .sync_out(sync_lv)
   );

   assign sub_sync = sync_lv[1];
   assign cfg_sync = sync_lv[0];

   // APB slave and registers
   pcoc_pkg::pcoc_apb_e apb_reg;
   pcoc_pkg::pcoc_apb_e apb_next;
   pcoc_pkg::pcoc_ctrl_s ctrl_reg;
   pcoc_pkg::pcoc_ctrl_s ctrl_next;
   logic stale_reg;
   logic stale_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [7:0] ctrl_byte;
   logic [7:0] stat_byte;
   logic hit_ctrl;
   logic hit_stat;
   logic wr_commit;
   logic sif_eff;
   logic sif_eff_reg;
   logic sif_rise;
   logic clk_run;

   // Readback byte; the unimplemented low bit is tied to zero
   // bit 0 reads zero
   assign ctrl_byte = {ctrl_reg, 1'b0};
   assign hit_ctrl = addr_is(paddr, `PCOC_CTRL_OFS);
   assign hit_stat = addr_is(paddr, `PCOC_STAT_OFS);
   // A write lands only at the edge where pready is seen high
   assign wr_commit = (apb_reg == pcoc_pkg::PCOC_APB_DONE) && psel &&
                      penable && pwrite;

   // Status readback shows the block's own live state
   always_comb begin
      stat_byte = 8'h00;
      stat_byte[`PCOC_ST_STALE] = stale_reg;
      stat_byte[`PCOC_ST_ACTIVE] = sif_eff_reg;
      stat_byte[`PCOC_ST_CLKRUN] = clk_run;
      stat_byte[`PCOC_ST_SLEEP] = sleep_req;
      stat_byte[`PCOC_ST_CFGOPT] = cfg_sync;
   end

   // Bus state, read data and one wait state before pready
   always_comb begin
      apb_next = apb_reg;
      prdata_next = prdata_reg;
      pready_next = pready_reg;
      pslverr_next = pslverr_reg;
      if (ce) begin
         unique case (apb_reg)
            pcoc_pkg::PCOC_APB_IDLE: begin
               if (psel && penable) begin
                  apb_next = pcoc_pkg::PCOC_APB_DONE;
                  pready_next = 1'b1;
                  pslverr_next = !(hit_ctrl || hit_stat);
                  if (pwrite || !(hit_ctrl || hit_stat)) begin
                     prdata_next = 32'h0000_0000;
                  end else if (hit_ctrl) begin
                     prdata_next = {24'h00_0000, ctrl_byte};
                  end else begin
                     prdata_next = {24'h00_0000, stat_byte};
                  end
               end
            end
            default: begin // Done and illegal codes return to idle
               apb_next = pcoc_pkg::PCOC_APB_IDLE;
               pready_next = 1'b0;
               pslverr_next = 1'b0;
            end
         endcase
      end
   end

   // Control register write; the masked low bit drops out of the struct
   always_comb begin
      ctrl_next = ctrl_reg;
      if (ce && wr_commit && hit_ctrl) begin
         ctrl_next = pcoc_pkg::pcoc_ctrl_s'(
            7'((pwdata[7:0] & `PCOC_CTRL_WMASK) >> 1));
      end
   end

   // Serial enable only counts when the configuration option allows it
   // gated by configuration option
   // unused code has no serial function
   assign sif_eff = ctrl_reg.sif_en && cfg_sync &&
                    (ctrl_reg.mode != pcoc_pkg::PCOC_MODE_UNUSED);
   assign sif_rise = sif_eff && !sif_eff_reg;

   // Stale flag: a fresh enable wins over a same-cycle clear
   // flag stale SPI contents
   always_comb begin
      stale_next = stale_reg;
      if (ce) begin
         if (sif_rise) begin
            stale_next = 1'b1;
         end else if (wr_commit && hit_stat && pwdata[`PCOC_ST_STALE]) begin
            stale_next = 1'b0;
         end
      end
   end

   // Register bus and control state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_reg <= pcoc_pkg::PCOC_APB_IDLE;
         ctrl_reg <= pcoc_pkg::pcoc_ctrl_s'(`PCOC_CTRL_RST);
         stale_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         apb_reg <= apb_next;
         ctrl_reg <= ctrl_next;
         stale_reg <= stale_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // Peripheral clock output and shared pin
   logic pck_reg;
   logic pck_next;
   logic tick_reg;
   logic tick_next;
   logic pck_lvl;
   pcoc_pkg::pcoc_pin_s pin_reg;
   pcoc_pkg::pcoc_pin_s pin_next;

   assign clk_run = ctrl_reg.pck_en && !sleep_req;

   // Source select; every divided level is already a flop bit
   // source select
   always_comb begin
      unique case (ctrl_reg.src)
         pcoc_pkg::PCOC_SRC_SYS: pck_lvl = 1'b1;
         pcoc_pkg::PCOC_SRC_DIV4: pck_lvl = div_tap(presc, `PCOC_TAP_DIV4);
         pcoc_pkg::PCOC_SRC_DIV8: pck_lvl = div_tap(presc, `PCOC_TAP_DIV8);
         pcoc_pkg::PCOC_SRC_T0: pck_lvl = t0_half;
      endcase
   end

   // Level and rising-edge tick; stopped output parks low
   // static low, flop driven
   always_comb begin
      pck_next = pck_reg;
      tick_next = tick_reg;
      pin_next = pin_reg;
      if (ce) begin
         pck_next = clk_run && pck_lvl;
         tick_next = (ctrl_reg.src == pcoc_pkg::PCOC_SRC_SYS) ? clk_run :
                     (clk_run && pck_lvl && !pck_reg);
         // enable bit picks clock or port
         if (ctrl_reg.pck_en) begin
            pin_next.o = clk_run && pck_lvl;
            pin_next.oe = 1'b1;
         end else begin
            pin_next = port_drive;
         end
      end
   end

   // Register the clock output path
   // internal pin only, no pad
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pck_reg <= 1'b0;
         tick_reg <= 1'b0;
         pin_reg <= '0;
      end else begin
         pck_reg <= pck_next;
         tick_reg <= tick_next;
         pin_reg <= pin_next;
      end
   end

   // Serial interface mode decode and master clock
   pcoc_pkg::pcoc_serial_s mode_reg;
   pcoc_pkg::pcoc_serial_s mode_next;
   pcoc_pkg::pcoc_pin_s sclk_reg;
   pcoc_pkg::pcoc_pin_s sclk_next;
   logic reinit_reg;
   logic reinit_next;
   logic oe_allow_reg;
   logic oe_allow_next;
   logic sif_eff_next;
   logic is_master;
   logic sclk_lvl;

   // Mode decode and master clock source
   // master clock rates
   always_comb begin
      is_master = 1'b0;
      sclk_lvl = 1'b0;
      unique case (ctrl_reg.mode)
         pcoc_pkg::PCOC_MODE_SPI_M4: begin
            is_master = 1'b1;
            sclk_lvl = div_tap(presc, `PCOC_TAP_DIV4);
         end
         pcoc_pkg::PCOC_MODE_SPI_M16: begin
            is_master = 1'b1;
            sclk_lvl = div_tap(presc, `PCOC_TAP_DIV16);
         end
         pcoc_pkg::PCOC_MODE_SPI_M64: begin
            is_master = 1'b1;
            sclk_lvl = div_tap(presc, `PCOC_TAP_DIV64);
         end
         pcoc_pkg::PCOC_MODE_SPI_MSUB: begin
            is_master = 1'b1;
            sclk_lvl = sub_sync;
         end
         pcoc_pkg::PCOC_MODE_SPI_MT0: begin
            is_master = 1'b1;
            sclk_lvl = t0_half;
         end
         pcoc_pkg::PCOC_MODE_SPI_SLV, pcoc_pkg::PCOC_MODE_I2C_SLV,
         pcoc_pkg::PCOC_MODE_UNUSED: is_master = 1'b0;
      endcase
   end

   // Serial outputs; slave modes never drive the clock line
   always_comb begin
      mode_next = mode_reg;
      sclk_next = sclk_reg;
      reinit_next = reinit_reg;
      oe_allow_next = oe_allow_reg;
      sif_eff_next = sif_eff_reg;
      if (ce) begin
         sif_eff_next = sif_eff;
         reinit_next = sif_rise;
         mode_next.spi_master = sif_eff && is_master;
         mode_next.spi_slave = sif_eff &&
            (ctrl_reg.mode == pcoc_pkg::PCOC_MODE_SPI_SLV);
         mode_next.i2c_slave = sif_eff &&
            (ctrl_reg.mode == pcoc_pkg::PCOC_MODE_I2C_SLV);
         mode_next.active = sif_eff;
         oe_allow_next = sif_eff;
         sclk_next.oe = sif_eff && is_master;
         sclk_next.o = sif_eff && is_master && sclk_lvl;
      end
   end

   // Register the serial outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= '0;
         sclk_reg <= '0;
         reinit_reg <= 1'b0;
         oe_allow_reg <= 1'b0;
         sif_eff_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         sclk_reg <= sclk_next;
         reinit_reg <= reinit_next;
         oe_allow_reg <= oe_allow_next;
         sif_eff_reg <= sif_eff_next;
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign periph_clock_out = pck_reg;
   assign periph_clock_tick = tick_reg;
   assign shared_port_pin = pin_reg;
   assign serial_sclk = sclk_reg;
   assign serial_mode = mode_reg;
   assign serial_lines_oe_allow = oe_allow_reg;
   assign spi_ctrl_reinit = reinit_reg;

endmodule // pcoc_top

/* File: design/pcoc_defines.svh */
// Purpose: Offsets, field positions, reset values and divider taps for
//          the peripheral clock output and serial mode control block.
// Assumes: APB byte addressing, 32-bit data, one register per word.
// Notes:   Only definitions live here; no logic.
`ifndef PCOC_DEFINES_SVH
`define PCOC_DEFINES_SVH

// APB map
`define PCOC_ADDR_W 12
`define PCOC_CTRL_OFS 12'h000
`define PCOC_STAT_OFS 12'h004

// Mode and clock control byte
`define PCOC_CTRL_RST 7'h70
`define PCOC_CTRL_WMASK 8'hfe

// Status register bit positions
`define PCOC_ST_STALE 0
`define PCOC_ST_ACTIVE 1
`define PCOC_ST_CLKRUN 2
`define PCOC_ST_SLEEP 3
`define PCOC_ST_CFGOPT 4

// Prescaler taps: bit n of the free counter runs at sysclk / 2^(n+1)
`define PCOC_PRESC_W 6
`define PCOC_TAP_DIV4 1
`define PCOC_TAP_DIV8 2
`define PCOC_TAP_DIV16 3
`define PCOC_TAP_DIV64 5

`endif

/* File: design/pcoc_pkg.sv */
// Purpose: Types shared by the peripheral clock output block.
// Assumes: Constants come from pcoc_defines.svh.
// Notes:   Enum codes follow the register field encodings.
package pcoc_pkg;

   typedef enum logic [1:0] {
      PCOC_SRC_SYS = 2'h0,
      PCOC_SRC_DIV4 = 2'h1,
      PCOC_SRC_DIV8 = 2'h2,
      PCOC_SRC_T0 = 2'h3
   } pcoc_src_e;

   typedef enum logic [2:0] {
      PCOC_MODE_SPI_M4 = 3'h0,
      PCOC_MODE_SPI_M16 = 3'h1,
      PCOC_MODE_SPI_M64 = 3'h2,
      PCOC_MODE_SPI_MSUB = 3'h3,
      PCOC_MODE_SPI_MT0 = 3'h4,
      PCOC_MODE_SPI_SLV = 3'h5,
      PCOC_MODE_I2C_SLV = 3'h6,
      PCOC_MODE_UNUSED = 3'h7
   } pcoc_mode_e;

   typedef enum logic [1:0] {
      PCOC_APB_IDLE = 2'h1,
      PCOC_APB_DONE = 2'h2
   } pcoc_apb_e;

   typedef struct packed {
      pcoc_mode_e mode;
      logic pck_en;
      pcoc_src_e src;
      logic sif_en;
   } pcoc_ctrl_s;

   typedef struct packed {
      logic spi_master;
      logic spi_slave;
      logic i2c_slave;
      logic active;
   } pcoc_serial_s;

   typedef struct packed {
      logic o;
      logic oe;
   } pcoc_pin_s;

endpackage

/* File: design/pcoc_sync2.sv */
// Purpose: Two-stage synchroniser for levels arriving from outside.
// Assumes: Inputs are slow levels; pulses shorter than one cycle may vanish.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
module pcoc_sync2 #(
   parameter int W = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] sync_reg;
   logic [W-1:0] sync_next;

   // Hold both stages while the clock enable is low
   always_comb begin
      meta_next = ce ? async_in : meta_reg;
      sync_next = ce ? meta_reg : sync_reg;
   end

   // Register the two stages
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;

endmodule // pcoc_sync2

/* File: design/pcoc_divider.sv */
// Purpose: Free-running sysclk prescaler and timer0 half-rate toggle.
// Assumes: timer0_out comes from logic on pclk, so it is not resynchronised.
// Notes:   Every derived clock is a flop bit, so none can glitch.
`timescale 1ns/100ps
`include "pcoc_defines.svh"
module pcoc_divider (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic timer0_out,
   output logic [`PCOC_PRESC_W-1:0] presc,
   output logic timer0_half
);

   logic [`PCOC_PRESC_W-1:0] presc_reg;
   logic [`PCOC_PRESC_W-1:0] presc_next;
   logic t0_prev_reg;
   logic t0_prev_next;
   logic half_reg;
   logic half_next;

   // Count while ce is high; toggle the half-rate clock on each timer0 rising edge
   always_comb begin
      presc_next = presc_reg;
      t0_prev_next = t0_prev_reg;
      half_next = half_reg;
      if (ce) begin
         presc_next = `PCOC_PRESC_W'(presc_reg + `PCOC_PRESC_W'(1));
         t0_prev_next = timer0_out;
         if (timer0_out && !t0_prev_reg) begin
            half_next = ~half_reg;
         end
      end
   end

   // Register the divider state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_reg <= '0;
         t0_prev_reg <= 1'b0;
         half_reg <= 1'b0;
      end else begin
         presc_reg <= presc_next;
         t0_prev_reg <= t0_prev_next;
         half_reg <= half_next;
      end
   end

   assign presc = presc_reg;
   assign timer0_half = half_reg;

endmodule // pcoc_divider

/* File: dv/pcoc_top_props.sv */
// Purpose: Concurrent checks on the ports of the clock output block.
// Assumes: One pclk domain; presetn is active low; ce is held high.
// Notes: Only ports are seen, so register contents are inferred.
`timescale 1ns/100ps
`include "pcoc_defines.svh"
module pcoc_top_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic [`PCOC_ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sleep_req,
   input wire logic periph_clock_out,
   input wire logic periph_clock_tick,
   input wire pcoc_pkg::pcoc_pin_s shared_port_pin,
   input wire pcoc_pkg::pcoc_pin_s serial_sclk,
   input wire pcoc_pkg::pcoc_serial_s serial_mode,
   input wire logic serial_lines_oe_allow,
   input wire logic spi_ctrl_reinit
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Answer comes one wait state after the setup cycle
   a_pready_timing: assert property (ce && psel && !penable |=> ##1 pready)
      else $error("pready late after setup");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_unmapped_err: assert property (pready |->
      pslverr == (paddr != 12'h000 && paddr != 12'h004))
      else $error("pslverr does not match address map");
   a_err_data_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response carries data");
   a_sleep_stops: assert property (
      $past(sleep_req) && sleep_req |-> !periph_clock_out)
      else $error("clock output runs in sleep");
   a_full_rate_high: assert property (
      periph_clock_tick && $past(periph_clock_tick) |-> periph_clock_out)
      else $error("full rate clock level low");
   a_pin_carries_clk: assert property (periph_clock_out |->
      shared_port_pin.oe && shared_port_pin.o)
      else $error("shared pin not carrying clock");
   a_sclk_master: assert property (serial_sclk.oe |->
      serial_mode.spi_master && serial_mode.active && serial_lines_oe_allow)
      else $error("serial clock driven outside active master");
   a_mode_onehot: assert property (serial_mode.active |->
      $onehot({serial_mode.spi_master, serial_mode.spi_slave,
      serial_mode.i2c_slave}))
      else $error("active serial mode not one hot");
   a_reinit_pulse: assert property (spi_ctrl_reinit |=>
      !spi_ctrl_reinit[*3])
      else $error("reinit pulse repeated");
endmodule // pcoc_top_props

bind pcoc_top pcoc_top_props u_props (.pclk, .presetn, .ce, .psel,
   .penable, .paddr, .prdata, .pready, .pslverr, .sleep_req,
   .periph_clock_out, .periph_clock_tick, .shared_port_pin, .serial_sclk,
   .serial_mode, .serial_lines_oe_allow, .spi_ctrl_reinit);

/* File: dv/pcoc_clk_sink.sv */
// Purpose: Internal consumer of the peripheral clock; measures its period.
// Assumes: The clock it sees is a pclk-domain flop output.
// Notes: Reports the spacing of the last two rising edges in pclk cycles.
`timescale 1ns/100ps
module pcoc_clk_sink (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_in,
   output logic [7:0] period
);
   logic prev_reg;
   logic [7:0] cnt_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= 1'h0;
         cnt_reg <= 8'h00;
         period <= 8'h00;
      end else begin
         prev_reg <= clk_in;
         if (clk_in && !prev_reg) begin
            period <= cnt_reg + 8'h01;
            cnt_reg <= 8'h00;
         end else begin
            cnt_reg <= cnt_reg + 8'h01;
         end
      end
   end
endmodule // pcoc_clk_sink

/* File: dv/pcoc_top_tb.sv */
// Purpose: Register, clock output and serial mode tests over APB.
// Assumes: ce held high; timer0 and sub clock made here.
// Notes: Periods come from the sink model, not from the design.
`timescale 1ns/100ps
module pcoc_top_tb;
   logic pclk, presetn, psel, penable, pwrite, sleep_req, timer0_out;
   logic sub_clock, cfg_serial_option;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, periph_clock_out, periph_clock_tick;
   logic serial_lines_oe_allow, spi_ctrl_reinit;
   pcoc_pkg::pcoc_pin_s port_drive, shared_port_pin, serial_sclk;
   pcoc_pkg::pcoc_serial_s serial_mode;
   logic [7:0] period, sclk_per;
   logic [2:0] t0_cnt;
   int num_errors, compares, reinits;

   pcoc_top dut (.pclk, .presetn, .ce(1'h1), .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_req, .timer0_out,
      .sub_clock, .cfg_serial_option, .port_drive, .periph_clock_out,
      .periph_clock_tick, .shared_port_pin, .serial_sclk, .serial_mode,
      .serial_lines_oe_allow, .spi_ctrl_reinit);
   pcoc_clk_sink sink (.pclk, .presetn, .clk_in(periph_clock_out), .period);
   // Second consumer measures the SPI master clock line
   pcoc_clk_sink sclk_sink (.pclk, .presetn, .clk_in(serial_sclk.o),
      .period(sclk_per));

   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end

   // Timer0 period 6 cycles, sub clock slower; count reinit pulses
   // Reset here keeps these sources with a single driving process
   always @(posedge pclk) begin
      if (!presetn) begin
         t0_cnt <= 3'h0;
         timer0_out <= 1'h0;
         sub_clock <= 1'h0;
      end else begin
         t0_cnt <= (t0_cnt == 3'h5) ? 3'h0 : t0_cnt + 3'h1;
         timer0_out <= (t0_cnt < 3'h3);
         if (t0_cnt == 3'h0) sub_clock <= ~sub_clock;
      end
      if (spi_ctrl_reinit === 1'h1) reinits++;
   end

   task automatic complete_run();
      if (num_errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         num_errors++;
         complete_run();
      end
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge pclk);
   endtask

   logic [7:0] exp_per [4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
   // SPI master periods: /4, /16, /64, sub clock 12, timer0 half 12
   logic [7:0] exp_sclk [5] = '{8'h04, 8'h10, 8'h40, 8'h0c, 8'h0c};

   initial begin
      {psel, penable, pwrite, sleep_req} = 4'h0;
      {paddr, pwdata} = '0;
      cfg_serial_option = 1'h1;
      port_drive = 2'h3;
      presetn = 1'h0;
      settle(8);
      presetn <= 1'h1;
      settle(3);
      apb(1'h0, 12'h000, 32'h0);
      check(rd, 32'he0);
      apb(1'h0, 12'h004, 32'h0);
      check(rd, 32'h10);
      apb(1'h1, 12'h000, 32'hff);
      apb(1'h0, 12'h000, 32'h0);
      check(rd, 32'hfe);
      apb(1'h1, 12'h00c, 32'h0);
      check(err, 1'h1);
      check(rd, 32'h0);
      apb(1'h0, 12'h008, 32'h0);
      check(err, 1'h1);
      check(rd, 32'h0);
      apb(1'h0, 12'h000, 32'h0);
      check(rd, 32'hfe);
      // Divided sources, timer0 halved to 12 cycles
      for (int s = 1; s < 4; s++) begin
         apb(1'h1, 12'h000, 32'hf0 | (s << 2));
         settle(40);
         check(period, exp_per[s]);
         check(shared_port_pin.oe, 1'h1);
      end
      apb(1'h1, 12'h000, 32'hf0);
      settle(4);
      check({periph_clock_tick, periph_clock_out}, 2'h3);
      apb(1'h1, 12'h000, 32'he4);
      settle(3);
      check(periph_clock_out, 1'h0);
      check(shared_port_pin, port_drive);
      apb(1'h1, 12'h000, 32'hf4);
      sleep_req <= 1'h1;
      settle(3);
      check(periph_clock_out, 1'h0);
      apb(1'h0, 12'h004, 32'h0);
      check(rd, 32'h18);
      sleep_req <= 1'h0;
      // Every mode code with serial enable set
      for (int m = 0; m < 8; m++) begin
         apb(1'h1, 12'h000, (m << 5) | 32'h2);
         // Long enough for two rising edges of the slowest master rate
         settle(140);
         check(serial_mode, m < 5 ? 4'h9 : m == 5 ? 4'h5 :
            m == 6 ? 4'h3 : 4'h0);
         check(serial_sclk.oe, m < 5);
         if (m < 5) check(sclk_per, exp_sclk[m]);
         check(serial_lines_oe_allow, m < 7);
         if (m == 0) begin
            apb(1'h0, 12'h004, 32'h0);
            check(rd, 32'h13);
            apb(1'h1, 12'h004, 32'h1);
            apb(1'h0, 12'h004, 32'h0);
            check(rd, 32'h12);
         end
      end
      check(reinits, 1);
      apb(1'h1, 12'h000, 32'h02);
      cfg_serial_option <= 1'h0;
      settle(5);
      check({serial_mode.active, serial_lines_oe_allow}, 2'h0);
      cfg_serial_option <= 1'h1;
      settle(5);
      check(serial_mode, 4'h9);
      apb(1'h1, 12'h000, 32'h00);
      settle(3);
      check({serial_lines_oe_allow, serial_sclk.oe}, 2'h0);
      complete_run();
   end
endmodule // pcoc_top_tb
